// ==== hw/mtog_guard.sv ====
/*
  motor thermal overload guard: first-order heat model of the motor fed by output
  current, low-speed derating, overload alarm, early warning and interrupt.
  assumes output current (0.01 a) and frequency (0.01 hz) arrive synchronous to
  hclk, and one ahb-lite master with hsel decoded outside.
*/
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module mtog_guard
  import mtog_pkg::*;
#(
  parameter int unsigned TICK_BASE_CYCLES = 32'(MTOG_TICK_CYC)
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // drive measurements
  input wire logic [15:0] out_current,
  input wire logic [15:0] out_freq,
  // alarm outputs
  output logic overload_alarm,
  output logic early_warning,
  output logic irq
);
  // bus phase capture
  logic wr_pend_q, wr_pend_d;        // write data phase pending
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  // software state
  mtog_ctrl_t ctrl_q, ctrl_d;
  logic [15:0] level_q, level_d;     // overload_detect_level
  logic [9:0] tau_q, tau_d;          // thermal_time_const
  logic [15:0] base_q, base_d;
  logic [MTOG_ST_W-1:0] stat_q, stat_d, mask_q, mask_d;
  // model state
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic [9:0] tau_cnt_q, tau_cnt_d;
  logic heat_tick;                   // one pulse per model step
  logic [6:0] alpha_q, alpha_d;      // present characteristic factor
  logic [47:0] heat_q, heat_d;
  logic warn_q, warn_d;
  // combinational helpers
  logic addr_ok;
  logic [15:0] bp33;
  logic [47:0] target, thr, heat_nx;
  logic [22:0] base33;
  logic [9:0] wtau;

  assign addr_ok = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;           // zero wait states
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign overload_alarm = stat_q[MTOG_ST_TRIP];
  assign early_warning = warn_q;
  assign irq = |(stat_q & mask_q);

  // derived breakpoint: a third of base frequency
  assign base33 = 23'(base_q * MTOG_BP_PCT);
  assign bp33 = 16'(base33 / 23'(MTOG_PCT_FULL));
  // target in current squared times ten thousand, threshold in (level*alpha)^2
  assign target = 48'(32'(out_current * out_current) * 48'd10000);
  assign thr = 48'(23'(level_q * alpha_q) * 23'(level_q * alpha_q));
  assign heat_tick = (tick_cnt_q == TICK_BASE_CYCLES - 1) && (tau_cnt_q == tau_q - 10'h001);

  // bus address phase, read data and register writes
  always_comb begin
    wr_pend_d = addr_ok && hwrite;
    wr_addr_d = addr_ok ? haddr : wr_addr_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    level_d = level_q;
    tau_d = tau_q;
    base_d = base_q;
    mask_d = mask_q;
    wtau = hwdata[9:0];
    if (addr_ok && !hwrite) begin
      case (haddr)
        MTOG_CTRL_ADDR: rdata_d = {24'h0, ctrl_q};
        MTOG_LEVEL_ADDR: rdata_d = {16'h0, level_q};
        MTOG_TAU_ADDR: rdata_d = {22'h0, tau_q};
        MTOG_BASE_ADDR: rdata_d = {16'h0, base_q};
        MTOG_STAT_ADDR: rdata_d = {29'h0, warn_q, stat_q};
        MTOG_MASK_ADDR: rdata_d = {30'h0, mask_q};
        MTOG_HEAT_ADDR: rdata_d = heat_q[47:16];
        MTOG_FACT_ADDR: rdata_d = {25'h0, alpha_q};
        default: rdata_d = 32'h0; // unmapped reads as zero
      endcase
    end
    if (wr_pend_q) begin
      case (wr_addr_q)
        MTOG_CTRL_ADDR: ctrl_d = hwdata[7:0];
        MTOG_LEVEL_ADDR: level_d = hwdata[15:0];
        MTOG_TAU_ADDR: begin
          // out of range settings are clamped, not refused
          if (hwdata[31:10] != 22'h0 || wtau > MTOG_TAU_MAX) begin
            tau_d = MTOG_TAU_MAX;
          end else if (wtau < MTOG_TAU_MIN) begin
            tau_d = MTOG_TAU_MIN;
          end else begin
            tau_d = wtau;
          end
        end
        MTOG_BASE_ADDR: base_d = hwdata[15:0];
        MTOG_MASK_ADDR: mask_d = hwdata[MTOG_ST_W-1:0];
        default: ; // other writes are ignored
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
      rdata_q <= 32'h0;
      ctrl_q <= MTOG_CTRL_RST;
      level_q <= 16'h0;
      tau_q <= MTOG_TAU_RST;
      base_q <= MTOG_BASE_RST;
      mask_q <= '0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      level_q <= level_d;
      tau_q <= tau_d;
      base_q <= base_d;
      mask_q <= mask_d;
    end
  end

  // characteristic factor from cooling, motor type, size and frequency
  always_comb begin
    alpha_d = MTOG_PCT_FULL;
    if (ctrl_q.cooling_type_select == MTOG_COOL_SHAFT) begin
      if (ctrl_q.motor_type_select == MTOG_MT_B1 ||
          ctrl_q.motor_type_select == MTOG_MT_B3) begin
        // both breakpoints coincide, so the middle factor never applies
        alpha_d = (out_freq < bp33) ? MTOG_A69 : MTOG_A90;
      end else begin
        // types 0 and 4; other codes fall back to the same table
        case (ctrl_q.size_class)
          3'h0: alpha_d = (out_freq < MTOG_F5HZ) ? MTOG_A75 :
                          (out_freq < MTOG_F7HZ) ? MTOG_A85 : MTOG_PCT_FULL;
          3'h1, 3'h3: alpha_d = (out_freq < MTOG_F7HZ) ? MTOG_A85 : MTOG_PCT_FULL;
          3'h2: alpha_d = (out_freq < MTOG_F5HZ) ? MTOG_A90 :
                          (out_freq < MTOG_F6HZ) ? MTOG_A95 : MTOG_PCT_FULL;
          3'h4: alpha_d = (out_freq < MTOG_F5HZ) ? MTOG_A92 : MTOG_PCT_FULL;
          default: alpha_d = MTOG_PCT_FULL;
        endcase
      end
    end
  end

  // model step timer: base ticks, then tau base ticks per step
  always_comb begin
    tick_cnt_d = tick_cnt_q + 32'h1;
    tau_cnt_d = tau_cnt_q;
    if (tick_cnt_q >= TICK_BASE_CYCLES - 1) begin
      tick_cnt_d = 32'h0;
      // step period scales with tau so the leak stays a plain shift
      tau_cnt_d = (tau_cnt_q >= tau_q - 10'h001) ? 10'h0 : tau_cnt_q + 10'h001;
    end
  end

  // heat model, warning and sticky status
  always_comb begin
    heat_nx = heat_q;
    if (target >= heat_q) begin
      heat_nx = heat_q + ((target - heat_q) >> MTOG_LEAK_SHIFT);
    end else begin
      heat_nx = heat_q - ((heat_q - target) >> MTOG_LEAK_SHIFT);
    end
    heat_d = heat_q;
    warn_d = warn_q;
    stat_d = stat_q;
    // write one to clear, an event in the same cycle wins
    if (wr_pend_q && wr_addr_q == MTOG_STAT_ADDR) begin
      stat_d = stat_q & ~hwdata[MTOG_ST_W-1:0];
    end
    if (level_q == 16'h0) begin
      heat_d = 48'h0;
      warn_d = 1'b0;
    end else if (heat_tick) begin
      heat_d = heat_nx;
      // same model and time constant as the trip path
      warn_d = (heat_nx << MTOG_WARN_SH) >= 48'(thr * MTOG_WARN_NUM);
      if (heat_nx >= thr) begin
        stat_d[MTOG_ST_TRIP] = 1'b1;
      end
      if (warn_d && !warn_q) begin
        stat_d[MTOG_ST_WARN] = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 32'h0;
      tau_cnt_q <= 10'h0;
      alpha_q <= MTOG_PCT_FULL;
      heat_q <= 48'h0;
      warn_q <= 1'b0;
      stat_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tau_cnt_q <= tau_cnt_d;
      alpha_q <= alpha_d;
      heat_q <= heat_d;
      warn_q <= warn_d;
      stat_q <= stat_d;
    end
  end

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_const_cool;
    ctrl_q.cooling_type_select == MTOG_COOL_CONST |=> alpha_q == MTOG_PCT_FULL;
  endproperty
  a_const_cool: assert property (p_const_cool) else $error("constant cooling derated");

  property p_off;
    level_q == 16'h0 && !overload_alarm |=> !overload_alarm && heat_q == 48'h0;
  endproperty
  a_off: assert property (p_off) else $error("alarm while disabled");

  property p_warn_step;
    $rose(early_warning) |-> $past(heat_tick) && $past(level_q) != 16'h0;
  endproperty
  a_warn_step: assert property (p_warn_step) else $error("warning off model step");

  property p_trip;
    heat_tick && level_q != 16'h0 && heat_nx >= thr |=> overload_alarm;
  endproperty
  a_trip: assert property (p_trip) else $error("trip missed");

  property p_trip_cause;
    $rose(overload_alarm) |-> $past(heat_tick) && $past(level_q) != 16'h0;
  endproperty
  a_trip_cause: assert property (p_trip_cause) else $error("alarm without step");

  property p_tau_range;
    tau_q >= MTOG_TAU_MIN && tau_q <= MTOG_TAU_MAX;
  endproperty
  a_tau_range: assert property (p_tau_range) else $error("tau out of range");

  property p_size2;
    ctrl_q.cooling_type_select == MTOG_COOL_SHAFT && ctrl_q.motor_type_select == MTOG_MT_A0
      && ctrl_q.size_class == 3'h2 && out_freq >= MTOG_F5HZ && out_freq < MTOG_F6HZ
      |=> alpha_q == MTOG_A95;
  endproperty
  a_size2: assert property (p_size2) else $error("mid factor wrong");

  property p_high_f;
    ctrl_q.motor_type_select == MTOG_MT_A4 && out_freq >= MTOG_F7HZ
      |=> alpha_q == MTOG_PCT_FULL;
  endproperty
  a_high_f: assert property (p_high_f) else $error("high speed derated");

  property p_third;
    ctrl_q.cooling_type_select == MTOG_COOL_SHAFT && ctrl_q.motor_type_select == MTOG_MT_B3
      && out_freq < bp33 ##1 $stable(out_freq) |-> alpha_q == MTOG_A69;
  endproperty
  a_third: assert property (p_third) else $error("low factor wrong");

  property p_irq;
    ##1 irq == |($past(stat_d) & $past(mask_d));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
endmodule

// ==== hw/mtog_pkg.sv ====
/*
  constants, register map and field layout of the motor thermal overload guard.
  assumes a 125 MHz system clock and a 32-bit ahb-lite register bus.
*/
package mtog_pkg;
  // register byte addresses
  localparam logic [7:0] MTOG_CTRL_ADDR = 8'h00;
  localparam logic [7:0] MTOG_LEVEL_ADDR = 8'h04;
  localparam logic [7:0] MTOG_TAU_ADDR = 8'h08;
  localparam logic [7:0] MTOG_BASE_ADDR = 8'h0c;
  localparam logic [7:0] MTOG_STAT_ADDR = 8'h10;
  localparam logic [7:0] MTOG_MASK_ADDR = 8'h14;
  localparam logic [7:0] MTOG_HEAT_ADDR = 8'h18;
  localparam logic [7:0] MTOG_FACT_ADDR = 8'h1c;
  // cooling and motor type codes
  localparam logic [1:0] MTOG_COOL_SHAFT = 2'h1;
  localparam logic [1:0] MTOG_COOL_CONST = 2'h2;
  localparam logic [2:0] MTOG_MT_A0 = 3'h0;
  localparam logic [2:0] MTOG_MT_A4 = 3'h4;
  localparam logic [2:0] MTOG_MT_B1 = 3'h1;
  localparam logic [2:0] MTOG_MT_B3 = 3'h3;
  // control register layout, carried as one struct
  typedef struct packed {
    logic [2:0] size_class;          // 0:<=1hp 1:2-5 2:7.5-15 3:20 4:25-30
    logic [2:0] motor_type_select;
    logic [1:0] cooling_type_select;
  } mtog_ctrl_t;
  localparam mtog_ctrl_t MTOG_CTRL_RST = '{3'h0, 3'h0, MTOG_COOL_SHAFT};
  // thermal time constant in tenths of a minute
  localparam logic [9:0] MTOG_TAU_MIN = 10'h005;
  localparam logic [9:0] MTOG_TAU_MAX = 10'h2ee;
  localparam logic [9:0] MTOG_TAU_RST = 10'h032;
  // base frequency, 0.01 hz units, reset 60.00 hz
  localparam logic [15:0] MTOG_BASE_RST = 16'h1770;
  // breakpoints in 0.01 hz
  localparam logic [15:0] MTOG_F5HZ = 16'h01f4;
  localparam logic [15:0] MTOG_F6HZ = 16'h0258;
  localparam logic [15:0] MTOG_F7HZ = 16'h02bc;
  localparam logic [6:0] MTOG_BP_PCT = 7'h21;
  localparam logic [6:0] MTOG_PCT_FULL = 7'h64;
  // characteristic factors in percent
  localparam logic [6:0] MTOG_A69 = 7'h45;
  localparam logic [6:0] MTOG_A75 = 7'h4b;
  localparam logic [6:0] MTOG_A85 = 7'h55;
  localparam logic [6:0] MTOG_A90 = 7'h5a;
  localparam logic [6:0] MTOG_A92 = 7'h5c;
  localparam logic [6:0] MTOG_A95 = 7'h5f;
  // status bits
  localparam int MTOG_ST_TRIP = 0;
  localparam int MTOG_ST_WARN = 1;
  localparam int MTOG_ST_W = 2;
  // heat model: leak shift per tick, leak period ratio 1/ln(2.25/1.25) in milli
  localparam int MTOG_LEAK_SHIFT = 8;
  localparam longint MTOG_LEAK_MILLI = 1701;
  localparam longint MTOG_CLK_HZ = 125000000;
  localparam longint MTOG_TAU_UNIT_S = 6;
  localparam longint MTOG_TICK_CYC = MTOG_TAU_UNIT_S * MTOG_CLK_HZ * MTOG_LEAK_MILLI
                                     / (1000 * (64'h1 << MTOG_LEAK_SHIFT));
  // early warning at three quarters of the trip level
  localparam int MTOG_WARN_NUM = 3;
  localparam int MTOG_WARN_SH = 2;
endpackage

// ==== testbench/mtog_guard_tb.sv ====
/*
  self-checking bench for the motor thermal overload guard: register reset
  values, time constant range, derating table, disable, trip timing, interrupt.
  assumes the model step is shortened through TICK_BASE_CYCLES.
*/
`timescale 1ns/1ps
module mtog_guard_tb;
  import mtog_pkg::*;
  localparam int TB_TICK = 2; // short model step keeps the trip near 1500 cycles
  // bus and measurement signals
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, r;
  logic [15:0] out_current, out_freq;
  logic overload_alarm, early_warning, irq;
  logic rd_phase; // high during a read data phase
  logic [31:0] exp_q[$];
  string name_q[$];
  int n_mismatch, check_count, n, w;
  // derating table: control word, frequency, expected factor
  // the last four rows reach the size classes 4, 1, 0 and 3 in their derated bands
  logic [7:0] tc[11] = '{8'h41, 8'h41, 8'h41, 8'h11, 8'h85, 8'h0d, 8'h42, 8'h81, 8'h31,
    8'h01, 8'h61};
  logic [15:0] tf[11] = '{16'h0190, 16'h0226, 16'h03e8, 16'h0190, 16'h03e8, 16'h0bb8,
    16'h0190, 16'h0190, 16'h0258, 16'h0258, 16'h0258};
  logic [6:0] te[11] = '{MTOG_A90, MTOG_A95, MTOG_PCT_FULL, MTOG_A75, MTOG_A69, MTOG_A90,
    MTOG_PCT_FULL, MTOG_A92, MTOG_A85, MTOG_A85, MTOG_A85};
  assign hready = hreadyout; // single slave
  mtog_guard #(.TICK_BASE_CYCLES(TB_TICK)) mtog_guard_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .out_current(out_current), .out_freq(out_freq), .overload_alarm(overload_alarm),
    .early_warning(early_warning), .irq(irq));
  // 125 MHz clock
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // compare and count
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // single verdict point of the run
  task print_verdict;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // wait for hready under a bound, a hang counts as a mismatch
  task wait_ready;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
  endtask
  // one single word transfer: address phase, then data phase
  task bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr_en;
    haddr <= a;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_phase <= !wr_en;
    wait_ready();
    rd_phase <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
    bus(1'b0, a, 32'h0);
  endtask
  // read data is taken at the edge that closes the data phase
  always @(posedge hclk) begin
    if (rd_phase === 1'b1 && hready === 1'b1 && exp_q.size() > 0) begin
      check(name_q.pop_front(), hrdata, exp_q.pop_front());
      check("hresp", 32'(hresp), 32'h0);
    end
  end
  // watchdog, 50000 cycles, far beyond the few thousand cycles the tests need
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end
  // main sequence
  initial begin
    {hsel, hwrite, rd_phase, hresetn} = 4'h0;
    htrans = 2'h0;
    haddr = 8'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    out_current = 16'h0;
    out_freq = 16'h0;
    n_mismatch = 0;
    check_count = 0;
    r = $urandom(78);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values and an unmapped place
    rd(MTOG_CTRL_ADDR, 32'h1, "ctrl");
    rd(MTOG_LEVEL_ADDR, 32'h0, "level");
    rd(MTOG_TAU_ADDR, 32'(MTOG_TAU_RST), "tau");
    rd(MTOG_BASE_ADDR, 32'(MTOG_BASE_RST), "base");
    rd(MTOG_STAT_ADDR, 32'h0, "status");
    rd(MTOG_MASK_ADDR, 32'h0, "mask");
    bus(1'b1, 8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0, "unmapped");
    // time constant limits are clamped
    bus(1'b1, MTOG_TAU_ADDR, 32'h0);
    rd(MTOG_TAU_ADDR, 32'(MTOG_TAU_MIN), "tau_lo");
    bus(1'b1, MTOG_TAU_ADDR, 32'h400);
    rd(MTOG_TAU_ADDR, 32'(MTOG_TAU_MAX), "tau_hi");
    // derating factors per cooling, motor type, size and frequency
    for (int i = 0; i < 11; i++) begin
      out_freq <= tf[i];
      bus(1'b1, MTOG_CTRL_ADDR, 32'(tc[i]));
      rd(MTOG_FACT_ADDR, 32'(te[i]), "factor");
    end
    // random low speeds and base frequencies
    for (int i = 0; i < 4; i++) begin
      r = $urandom_range(1979, 0);
      out_freq <= r[15:0];
      bus(1'b1, MTOG_CTRL_ADDR, 32'h85);
      rd(MTOG_FACT_ADDR, 32'(MTOG_A69), "factor_rnd");
      bus(1'b1, MTOG_CTRL_ADDR, 32'h42);
      rd(MTOG_FACT_ADDR, 32'(MTOG_PCT_FULL), "factor_const");
      r = $urandom_range(65535, 0);
      bus(1'b1, MTOG_BASE_ADDR, r);
      rd(MTOG_BASE_ADDR, r, "base_rnd");
      // the next low speed draw assumes the 60 hz base, so restore it each pass
      bus(1'b1, MTOG_BASE_ADDR, 32'(MTOG_BASE_RST));
    end
    // heavy load with protection off: nothing may happen
    bus(1'b1, MTOG_TAU_ADDR, 32'h5);
    out_current <= 16'd150;
    out_freq <= 16'h1770;
    repeat (1700) @(posedge hclk);
    check("alarm_off", 32'(overload_alarm), 32'h0);
    check("warn_off", 32'(early_warning), 32'h0);
    rd(MTOG_HEAT_ADDR, 32'h0, "heat_off");
    // 150 percent of the level trips after one time constant
    bus(1'b1, MTOG_MASK_ADDR, 32'h1);
    bus(1'b1, MTOG_LEVEL_ADDR, 32'd100);
    n = 0;
    w = 0;
    while (overload_alarm !== 1'b1 && n < 3000) begin
      @(posedge hclk);
      n++;
      if (early_warning === 1'b1 && w == 0) w = n;
    end
    check("warn_time", 32'(w >= 900 && w <= 1200), 32'h1);
    check("trip_time", 32'(n >= 1400 && n <= 1650), 32'h1);
    @(negedge hclk);
    check("irq_on", 32'(irq), 32'h1);
    rd(MTOG_STAT_ADDR, 32'h7, "status_trip");
    bus(1'b1, MTOG_MASK_ADDR, 32'h0);
    @(negedge hclk);
    check("irq_masked", 32'(irq), 32'h0);
    // disabling drops the live warning, the sticky bits stay
    bus(1'b1, MTOG_LEVEL_ADDR, 32'h0);
    repeat (20) @(posedge hclk);
    rd(MTOG_STAT_ADDR, 32'h3, "status_off");
    check("alarm_held", 32'(overload_alarm), 32'h1);
    bus(1'b1, MTOG_MASK_ADDR, 32'h2);
    @(negedge hclk);
    check("irq_warn", 32'(irq), 32'h1);
    bus(1'b1, MTOG_STAT_ADDR, 32'h1);
    @(negedge hclk);
    check("alarm_clr", 32'(overload_alarm), 32'h0);
    rd(MTOG_STAT_ADDR, 32'h2, "status_w1c");
    bus(1'b1, MTOG_STAT_ADDR, 32'h2);
    @(negedge hclk);
    check("irq_clr", 32'(irq), 32'h0);
    rd(MTOG_STAT_ADDR, 32'h0, "status_clr");
    print_verdict();
  end
endmodule
